// File: inc/sdc_pkg.sv
package sdc_pkg;
    // Contract
    // - filter is cubic sinc: three cascaded length-N averages, each scaled 1/N
    // - output word rate is clock over N times 128; first notch there
    // - changing the filter word rescales frequencies, never the shape
    // - notches at every multiple of the first, deeper than 100 dB
    // - cutoff at 0.262 times the first notch frequency
    // - linear phase, group delay proportional to N over modulator rate
    // - unsynchronised step may leave up to four invalid output periods
    // - synchronised step settles in exactly three output periods
    // - channel change restarts filter; data held back three periods
    // - decimate modulator samples taken at clock over 128
    // - mode select write accepted any time, starts chosen calibration
    // - host reads and writes 24-bit offset and full-scale coefficients
    // - subtract normalised offset first, then apply full-scale as gain
    // - zero-scale and full-scale results stored for selected channel
    // - 33-bit internal precision, results delivered as 16 or 24 bits
    // - polarity changes only coding and calibration points; mid-scale zero
    // - calibration end returns mode select bits to 0, 0, 0
    localparam int MOD_DIV   = 128;
    localparam int MOD_CNT_W = 7;
    localparam int CIC_ORDER = 3;
    localparam int FW_W      = 12;
    localparam int ACC_W     = 37;
    localparam int INT_W     = 33;
    localparam int RES_W     = 24;
    localparam int Q_W       = 25;
    localparam int DIV_STEPS = 25;
    localparam logic [11:0] FW_MIN     = 12'h002;
    localparam logic [11:0] FW_RST     = 12'h0F0;
    localparam logic [1:0]  SETTLE_OUT = 2'h3;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_ZS   = 8'h10;
    localparam logic [7:0] OFS_FS   = 8'h14;
    localparam int STAT_NEW     = 0;
    localparam int STAT_SETTLED = 1;
    localparam int STAT_BUSY    = 2;
    localparam logic [2:0] MODE_NORMAL    = 3'h0;
    localparam logic [2:0] MODE_SELF_FULL = 3'h1;
    localparam logic [2:0] MODE_SYS_ZS    = 3'h2;
    localparam logic [2:0] MODE_SYS_FS    = 3'h3;
    localparam logic [2:0] MODE_SELF_ZS   = 3'h6;
    localparam logic [2:0] MODE_SELF_FS   = 3'h7;
    localparam logic [23:0] ZS_RST   = 24'h000000;
    localparam logic [23:0] FS_RST   = 24'hFFFFFF;
    localparam logic [23:0] MID_CODE = 24'h800000;
    typedef struct packed {
        logic        resync;
        logic [1:0]  chan;
        logic        word24;
        logic        bipolar;
        logic [11:0] fword;
    } sdc_ctrl_t;
    localparam sdc_ctrl_t CTRL_RST = '{resync: 1'b0, chan: 2'h0,
        word24: 1'b1, bipolar: 1'b0, fword: FW_RST};
    typedef enum logic [1:0] {
        CAL_RUN = 2'b00,
        CAL_ZS  = 2'b01,
        CAL_FS  = 2'b11
    } sdc_cal_t;
    typedef enum logic [1:0] {
        DV_IDLE = 2'b00,
        DV_NORM = 2'b01,
        DV_CORR = 2'b11
    } sdc_div_t;
endpackage

// File: logic/sdc_core.sv
`timescale 1ns/1ps
module sdc_core
    import sdc_pkg::*;
#(
    parameter int NCH = 3
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        mod_bit,
    input  wire logic        resync_n,
    output logic             data_new,
    output sdc_cal_t         cal_phase
);
    if (NCH < 1 || NCH > 4) begin : g_chk
        $error("NCH must lie in 1..4");
    end

    logic [1:0] mod_sync_q;
    logic [1:0] rs_sync_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mod_sync_q <= 2'h0;
            rs_sync_q  <= 2'h3;
        end else begin
            mod_sync_q <= {mod_sync_q[0], mod_bit};
            rs_sync_q  <= {rs_sync_q[0], resync_n};
        end
    end

    // filter: integrators at modulator rate, combs at output rate
    sdc_ctrl_t          ctrl_q;
    logic               restart_q;
    logic [MOD_CNT_W-1:0] pre_q, pre_d;
    logic [FW_W-1:0]    dec_q, dec_d;
    logic [ACC_W-1:0]   integ_q [CIC_ORDER];
    logic [ACC_W-1:0]   integ_d [CIC_ORDER];
    logic [ACC_W-1:0]   dly_q   [CIC_ORDER];
    logic [ACC_W-1:0]   dly_d   [CIC_ORDER];
    logic [ACC_W-1:0]   sum_q, sum_d, cmb_v;
    logic [1:0]         settle_q, settle_d;
    logic               go_q, go_d, tick, out_ev;
    logic [FW_W-1:0]    nword;
    logic [ACC_W-1:0]   ncube;

    assign nword = (ctrl_q.fword < FW_MIN) ? FW_MIN : ctrl_q.fword;
    // unity dc gain of each stage means dividing by N cubed
    assign ncube = ACC_W'(nword) * ACC_W'(nword) * ACC_W'(nword);
    assign tick  = pre_q == MOD_CNT_W'(MOD_DIV - 1);
    assign out_ev = tick && (dec_q == nword - 12'h001);

    always_comb begin
        pre_d    = pre_q + 1'b1;
        dec_d    = dec_q;
        integ_d  = integ_q;
        dly_d    = dly_q;
        sum_d    = sum_q;
        settle_d = settle_q;
        go_d     = 1'b0;
        cmb_v    = '0;
        if (tick) begin
            integ_d[0] = integ_q[0] + ACC_W'(mod_sync_q[1]);
            for (int i = 1; i < CIC_ORDER; i++) begin
                integ_d[i] = integ_q[i] + integ_d[i-1];
            end
            dec_d = out_ev ? '0 : dec_q + 12'h001;
        end
        if (out_ev) begin
            // wrap-around arithmetic keeps the comb result exact
            cmb_v = integ_d[CIC_ORDER-1];
            for (int i = 0; i < CIC_ORDER; i++) begin
                dly_d[i] = cmb_v;
                cmb_v    = cmb_v - dly_q[i];
            end
            sum_d = cmb_v;
            if (settle_q != SETTLE_OUT) begin
                settle_d = settle_q + 2'h1;
            end
            go_d = settle_q >= SETTLE_OUT - 2'h1;
        end
        if (restart_q) begin
            for (int i = 0; i < CIC_ORDER; i++) begin
                integ_d[i] = '0;
                dly_d[i]   = '0;
            end
            dec_d    = '0;
            settle_d = '0;
            go_d     = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_q    <= '0;
            dec_q    <= '0;
            integ_q  <= '{default: '0};
            dly_q    <= '{default: '0};
            sum_q    <= '0;
            settle_q <= '0;
            go_q     <= 1'b0;
        end else begin
            pre_q    <= pre_d;
            dec_q    <= dec_d;
            integ_q  <= integ_d;
            dly_q    <= dly_d;
            sum_q    <= sum_d;
            settle_q <= settle_d;
            go_q     <= go_d;
        end
    end

    // serial divider: normalisation pass, then correction pass
    sdc_div_t           dv_q, dv_d;
    sdc_cal_t           cal_q;
    logic [ACC_W-1:0]   rem_q, rem_d, den_q, den_d, sh_v;
    logic [Q_W-1:0]     quo_q, quo_d, qv;
    logic [4:0]         cnt_q, cnt_d;
    logic               neg_q, neg_d, dn_q, dn_d, dc_q, dc_d;
    logic [RES_W-1:0]   y_q, y_d;
    logic [INT_W-1:0]   diff_v, span_v, mag_v;
    logic [RES_W-1:0]   zs_q [NCH];
    logic [RES_W-1:0]   fs_q [NCH];
    logic [1:0]         ch;

    assign ch = (int'(ctrl_q.chan) < NCH) ? ctrl_q.chan : 2'h0;

    function automatic logic [RES_W-1:0] code_of(logic [Q_W-1:0] f,
                                                 logic neg, logic bip);
        logic [Q_W-1:0] s;
        s = '0;
        if (!bip) begin
            code_of = neg ? '0 : (f[Q_W-1] ? FS_RST : f[RES_W-1:0]);
        end else begin
            // mid-scale is zero input; half span each side
            s = neg ? {1'b0, MID_CODE} - {1'b0, f[Q_W-1:1]}
                    : {1'b0, MID_CODE} + {1'b0, f[Q_W-1:1]};
            code_of = s[Q_W-1] ? FS_RST : s[RES_W-1:0];
        end
    endfunction

    always_comb begin
        dv_d   = dv_q;
        rem_d  = rem_q;
        den_d  = den_q;
        quo_d  = quo_q;
        cnt_d  = cnt_q;
        neg_d  = neg_q;
        y_d    = y_q;
        dn_d   = 1'b0;
        dc_d   = 1'b0;
        sh_v   = (cnt_q == 5'h00) ? rem_q : {rem_q[ACC_W-2:0], 1'b0};
        qv     = {quo_q[Q_W-2:0], sh_v >= den_q};
        diff_v = '0;
        span_v = '0;
        mag_v  = '0;
        if (dv_q == DV_IDLE && go_q) begin
            dv_d  = DV_NORM;
            rem_d = sum_q;
            den_d = ncube;
            cnt_d = '0;
        end else if (dv_q != DV_IDLE) begin
            rem_d = (sh_v >= den_q) ? sh_v - den_q : sh_v;
            quo_d = qv;
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == 5'(DIV_STEPS - 1)) begin
                dv_d = DV_IDLE;
                if (dv_q == DV_CORR) begin
                    dc_d = 1'b1;
                    y_d  = code_of(qv, neg_q, ctrl_q.bipolar);
                end else if (cal_q != CAL_RUN) begin
                    dn_d = 1'b1;
                end else begin
                    // offset out first, then span as gain
                    diff_v = INT_W'(qv) - INT_W'(zs_q[ch]);
                    span_v = INT_W'(fs_q[ch]) - INT_W'(zs_q[ch]);
                    if ($signed(span_v) <= 0) begin
                        span_v = INT_W'(1);
                    end
                    mag_v = diff_v[INT_W-1] ? -diff_v : diff_v;
                    neg_d = diff_v[INT_W-1];
                    if (mag_v >= span_v) begin
                        dc_d = 1'b1;
                        y_d  = code_of({1'b1, 24'h000000}, neg_d,
                                       ctrl_q.bipolar);
                    end else begin
                        dv_d  = DV_CORR;
                        rem_d = ACC_W'(mag_v);
                        den_d = ACC_W'(span_v);
                        cnt_d = 5'h01;
                        quo_d = '0;
                    end
                end
            end
        end
        // a restart drops a pass in flight; only a result already done in the restart cycle still lands
        if (restart_q) begin
            dv_d = DV_IDLE;
            dn_d = 1'b0;
            dc_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dv_q  <= DV_IDLE;
            rem_q <= '0;
            den_q <= '0;
            quo_q <= '0;
            cnt_q <= '0;
            neg_q <= 1'b0;
            dn_q  <= 1'b0;
            dc_q  <= 1'b0;
            y_q   <= '0;
        end else begin
            dv_q  <= dv_d;
            rem_q <= rem_d;
            den_q <= den_d;
            quo_q <= quo_d;
            cnt_q <= cnt_d;
            neg_q <= neg_d;
            dn_q  <= dn_d;
            dc_q  <= dc_d;
            y_q   <= y_d;
        end
    end

    // register file, calibration sequencing
    sdc_ctrl_t          ctrl_d;
    sdc_cal_t           cal_d;
    logic [2:0]         mode_q, mode_d;
    logic [RES_W-1:0]   zs_d [NCH];
    logic [RES_W-1:0]   fs_d [NCH];
    logic [RES_W-1:0]   data_q, data_d, qsat;
    logic               new_q, new_d, restart_d;
    logic [31:0]        prdata_d;
    logic               pready_d, pslverr_d, acc, commit, wr;

    assign acc    = psel && penable && !pready;
    assign commit = psel && penable && pready;
    assign wr     = commit && pwrite;
    assign qsat   = quo_q[Q_W-1] ? FS_RST : quo_q[RES_W-1:0];

    always_comb begin
        ctrl_d    = ctrl_q;
        cal_d     = cal_q;
        mode_d    = mode_q;
        zs_d      = zs_q;
        fs_d      = fs_q;
        data_d    = data_q;
        new_d     = new_q;
        restart_d = !rs_sync_q[1];
        pready_d  = acc;
        pslverr_d = 1'b0;
        prdata_d  = prdata;
        if (acc) begin
            prdata_d = '0;
            unique case (paddr)
                OFS_CTRL: prdata_d = 32'({1'b0, ctrl_q[15:0]});
                OFS_MODE: prdata_d = 32'(mode_q);
                OFS_DATA: prdata_d = 32'(data_q);
                OFS_STAT: prdata_d = 32'({cal_q != CAL_RUN,
                                          settle_q == SETTLE_OUT, new_q});
                OFS_ZS:   prdata_d = 32'(zs_q[ch]);
                OFS_FS:   prdata_d = 32'(fs_q[ch]);
                default:  pslverr_d = 1'b1;
            endcase
        end
        if (commit && !pwrite && paddr == OFS_DATA) begin
            new_d = 1'b0;
        end
        if (wr && paddr == OFS_CTRL) begin
            ctrl_d = sdc_ctrl_t'(pwdata[16:0]);
            ctrl_d.resync = 1'b0;
            // notch or channel change restarts in step
            if (pwdata[16] || ctrl_d.chan != ctrl_q.chan ||
                ctrl_d.fword != ctrl_q.fword) begin
                restart_d = 1'b1;
            end
        end
        if (wr && paddr == OFS_ZS) begin
            zs_d[ch] = pwdata[RES_W-1:0];
        end
        if (wr && paddr == OFS_FS) begin
            fs_d[ch] = pwdata[RES_W-1:0];
        end
        if (dn_q) begin
            restart_d = 1'b1;
            if (cal_q == CAL_ZS) begin
                zs_d[ch] = qsat;
            end else begin
                fs_d[ch] = qsat;
            end
            if (cal_q == CAL_ZS && mode_q == MODE_SELF_FULL) begin
                cal_d = CAL_FS;
            end else begin
                cal_d  = CAL_RUN;
                mode_d = MODE_NORMAL;
            end
        end
        if (wr && paddr == OFS_MODE) begin
            // a new command aborts whatever is running
            mode_d    = pwdata[2:0];
            restart_d = 1'b1;
            unique case (pwdata[2:0])
                MODE_SELF_FULL, MODE_SYS_ZS, MODE_SELF_ZS: cal_d = CAL_ZS;
                MODE_SYS_FS, MODE_SELF_FS:                 cal_d = CAL_FS;
                default:                                   cal_d = CAL_RUN;
            endcase
        end
        if (dc_q) begin
            // set wins over a same-cycle read clear
            data_d = ctrl_q.word24 ? y_q : {8'h00, y_q[23:8]};
            new_d  = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q    <= CTRL_RST;
            cal_q     <= CAL_RUN;
            mode_q    <= MODE_NORMAL;
            zs_q      <= '{default: ZS_RST};
            fs_q      <= '{default: FS_RST};
            data_q    <= '0;
            new_q     <= 1'b0;
            restart_q <= 1'b1;
            prdata    <= '0;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            cal_q     <= cal_d;
            mode_q    <= mode_d;
            zs_q      <= zs_d;
            fs_q      <= fs_d;
            data_q    <= data_d;
            new_q     <= new_d;
            restart_q <= restart_d;
            prdata    <= prdata_d;
            pready    <= pready_d;
            pslverr   <= pslverr_d;
        end
    end

    assign data_new  = new_q;
    assign cal_phase = cal_q;

    // checks
    logic [19:0] per_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            per_q <= '0;
        end else begin
            per_q <= (out_ev || restart_q) ? 20'h00001 : per_q + 20'h00001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_cal_write;
        wr && paddr == OFS_MODE && pwdata[2:0] == MODE_SELF_ZS;
    endsequence
    sequence s_restarted;
        restart_q ##1 settle_q == 2'h0;
    endsequence

    chk_mod_tick_rate: assert property (tick |-> ##128 tick)
        else $error("modulator tick period is not 128");
    chk_out_period: assert property (out_ev && !restart_q &&
        $past(settle_q) != 2'h0 |-> per_q == 20'(nword) * 20'd128)
        else $error("output period differs from N times 128");
    chk_settle_gate: assert property (dc_q |->
        settle_q == SETTLE_OUT || restart_q)
        else $error("data updated before settling");
    chk_resync_clear: assert property (s_restarted |->
        integ_q[0] == '0 && dec_q == '0)
        else $error("restart left filter state");
    chk_cal_start: assert property (s_cal_write |=>
        cal_q == CAL_ZS && restart_q)
        else $error("calibration did not start on mode write");
    chk_mode_done: assert property (dn_q && cal_q == CAL_FS |=>
        mode_q == MODE_NORMAL && cal_q == CAL_RUN)
        else $error("mode bits not cleared after calibration");
    chk_cal_store: assert property (dn_q && cal_q == CAL_ZS |=>
        zs_q[ch] == $past(qsat))
        else $error("zero-scale result not stored");
    chk_div_length: assert property (disable iff (!reset_n || restart_q)
        $rose(dv_q == DV_NORM) |->
        (dv_q == DV_NORM)[*8] ##[18:18] dv_q != DV_NORM)
        else $error("normalisation pass length wrong");
    chk_apb_wait: assert property (acc |=> pready ##1 !pready)
        else $error("apb answer not one cycle");
endmodule

// File: test/sdc_core_bench.sv
`timescale 1ns/1ps
module sdc_core_bench
    import sdc_pkg::*;
();
    logic        clk      = 1'b0;
    logic        reset_n  = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0;
    logic [1:0]  level    = 2'h0;
    logic        sync_req = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        mod_bit;
    logic        resync_n;
    logic        data_new;
    sdc_cal_t    cal_phase;
    int          n_fail   = 0;
    int          total_checks = 0;
    int          cyc      = 0;

    always #12.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    sdc_core i_sdc_core (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mod_bit(mod_bit), .resync_n(resync_n), .data_new(data_new),
        .cal_phase(cal_phase));
    sdc_mod_model i_sdc_mod_model (.clk(clk), .reset_n(reset_n),
        .level(level), .sync_req(sync_req), .mod_bit(mod_bit),
        .resync_n(resync_n));

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t ns: seen %h expected %h", $time, got, exp);
        end
    endtask

    // request held until pready is seen, released at that same edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int k;
        k = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // pready read before this edge updates it, as the slave samples it
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_fail++;
            $display("Error %0t ns: bus answer missing", $time);
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        rd(a, r);
        check(r, exp);
    endtask

    task automatic set_ctrl(input logic [11:0] fw, input logic bip,
                            input logic w24, input logic [1:0] ch,
                            input logic rs);
        wr(OFS_CTRL, {15'h0, rs, ch, w24, bip, fw});
    endtask

    task automatic wait_new(output int t);
        int k;
        k = 0;
        // look only after the edge that may have cleared the flag
        do begin
            @(negedge clk);
            k++;
        end while (data_new !== 1'b1 && k < 4000);
        if (k >= 4000) begin
            n_fail++;
            $display("Error %0t ns: no new result", $time);
        end
        t = cyc;
    endtask

    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        rd_chk(OFS_CTRL, {15'h0, CTRL_RST});
        rd_chk(OFS_MODE, 32'h0);
        rd_chk(OFS_ZS, {8'h00, ZS_RST});
        rd_chk(OFS_FS, {8'h00, FS_RST});
        wr(OFS_ZS, 32'hAB123456);
        rd_chk(OFS_ZS, 32'h00123456);
        wr(OFS_FS, 32'h00FEDCBA);
        rd_chk(OFS_FS, 32'h00FEDCBA);
        apb(1'b0, 8'h18, 32'h0, r, e);
        check(r, 32'h0);
        check({31'h0, e}, 32'h1);
        wr(OFS_ZS, 32'h0);
        wr(OFS_FS, 32'h00FFFFFF);
    endtask

    task automatic t_rate();
        logic [11:0] nv[3] = '{12'h002, 12'h005, 12'h001};
        logic [31:0] r;
        int          t0;
        int          t1;
        level <= 2'h1;
        foreach (nv[i]) begin
            set_ctrl(nv[i], 1'b0, 1'b1, 2'h0, 1'b0);
            rd(OFS_DATA, r);
            wait_new(t0);
            rd_chk(OFS_DATA, 32'h00FFFFFF);
            wait_new(t0);
            rd(OFS_DATA, r);
            wait_new(t1);
            // lengths below the minimum behave as the minimum
            check(t1 - t0, ((nv[i] < FW_MIN) ? 2 : nv[i]) * MOD_DIV);
        end
    endtask

    task automatic t_settle();
        logic [31:0] r;
        int          t0;
        int          t1;
        int          d;
        for (int k = 0; k < 3; k++) begin
            t0 = cyc;
            if (k == 2) begin
                @(posedge clk);
                sync_req <= 1'b1;
                @(posedge clk);
                sync_req <= 1'b0;
            end else begin
                set_ctrl(12'h002, 1'b0, 1'b1, 2'(k + 1), 1'(k));
            end
            rd(OFS_DATA, r);
            wait_new(t1);
            d = t1 - t0;
            // three periods, first short by up to one sample, plus divider
            check({31'h0, d >= 640 && d <= 896}, 32'h1);
            rd_chk(OFS_STAT, 32'h00000003);
            rd_chk(OFS_DATA, 32'h00FFFFFF);
        end
        rd_chk(OFS_CTRL, 32'h0000A002);
        set_ctrl(12'h002, 1'b0, 1'b1, 2'h0, 1'b0);
    endtask

    task automatic t_cal();
        logic [2:0]  md[5] = '{MODE_SYS_ZS, MODE_SELF_ZS, MODE_SYS_FS,
                               MODE_SELF_FS, MODE_SELF_FULL};
        logic [1:0]  lv[5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h1};
        logic [23:0] ez[5] = '{24'h0, 24'h0, 24'h123456, 24'h123456,
                               24'hFFFFFF};
        logic [23:0] ef[5] = '{24'h654321, 24'h654321, 24'hFFFFFF,
                               24'hFFFFFF, 24'hFFFFFF};
        logic [31:0] r;
        int          k;
        foreach (md[i]) begin
            wr(OFS_ZS, 32'h00123456);
            wr(OFS_FS, 32'h00654321);
            level <= lv[i];
            wr(OFS_MODE, {29'h0, md[i]});
            @(posedge clk);
            check({30'h0, cal_phase},
                  (md[i][0] && md[i] != MODE_SELF_FULL) ? 32'h3 : 32'h1);
            k = 0;
            do begin
                rd(OFS_MODE, r);
                k++;
            end while (r[2:0] !== 3'h0 && k < 1000);
            check(r, 32'h0);
            check({30'h0, cal_phase}, 32'h0);
            rd_chk(OFS_ZS, {8'h00, ez[i]});
            rd_chk(OFS_FS, {8'h00, ef[i]});
        end
    endtask

    task automatic t_corr();
        logic [23:0] zs[8] = '{24'h0, 24'h0, 24'h0, 24'h0, 24'h400000,
                               24'h400000, 24'h400000, 24'h400000};
        logic [1:0]  lv[8] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h2,
                               2'h1, 2'h0};
        logic [7:0]  md[8] = '{8'h1, 8'h3, 8'h1, 8'h1, 8'h1, 8'h3,
                               8'h0, 8'h1};
        logic [23:0] ex[8] = '{24'h0, MID_CODE, 24'hFFFFFF, 24'h800000,
                               24'h800000, 24'hC00000, 24'h00FFFF, 24'h0};
        logic [31:0] r;
        int          t;
        foreach (zs[i]) begin
            wr(OFS_ZS, {8'h00, zs[i]});
            wr(OFS_FS, (zs[i] == 24'h0) ? 32'h00FFFFFF : 32'h00C00000);
            level <= lv[i];
            set_ctrl(12'h002, md[i][1], md[i][0], 2'h0, 1'b1);
            rd(OFS_DATA, r);
            wait_new(t);
            rd_chk(OFS_DATA, {8'h00, ex[i]});
        end
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        results();
    end

    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_rate();
        t_settle();
        t_cal();
        t_corr();
        results();
    end
endmodule

// File: test/sdc_mod_model.sv
`timescale 1ns/1ps
module sdc_mod_model (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [1:0] level,
    input  wire logic       sync_req,
    output logic            mod_bit,
    output logic            resync_n
);
    logic [6:0] ph_q;
    logic       alt_q;
    logic [2:0] hold_q;
    // level 0 all zeros, 1 all ones, 2 flips once per 128 clocks
    // flip period equals the sample period, so samples strictly alternate
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ph_q    <= 7'h00;
            alt_q   <= 1'b0;
            mod_bit <= 1'b0;
            hold_q  <= 3'h0;
        end else begin
            ph_q <= ph_q + 7'h01;
            if (ph_q == 7'h7F) begin
                alt_q <= ~alt_q;
            end
            mod_bit <= (level == 2'h2) ? alt_q : level[0];
            if (sync_req) begin
                hold_q <= 3'h4;
            end else if (hold_q != 3'h0) begin
                hold_q <= hold_q - 3'h1;
            end
        end
    end
    // four clocks low, longer than the double synchroniser
    assign resync_n = (hold_q == 3'h0);
endmodule
